// [asp_consts.svh]
// Timing, register offsets and field positions of the serial port
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
`define ASP_CLK_MHZ 250
`define ASP_DIV_RST 16'h00d9
`define ASP_REG_CTRL 12'h000
`define ASP_REG_DIV 12'h004
`define ASP_REG_TXD 12'h008
`define ASP_REG_RXD 12'h00c
`define ASP_REG_STAT 12'h010
`define ASP_REG_MASK 12'h014
`define ASP_REG_FLOW 12'h018
`define ASP_REG_LIN 12'h01c
`define ASP_CTRL_RST 32'h0000_0003
`define ASP_FLOW_RST 32'h0000_0c04
`define ASP_ST_RX 0
`define ASP_ST_TXE 1
`define ASP_ST_PE 2
`define ASP_ST_FE 3
`define ASP_ST_OE 4
`define ASP_ST_BI 5
`define ASP_NST 6
`define ASP_FIFO_DEPTH 16
`endif

// [asp_dev_end.sv]
// Serial port device end: APB registers, FIFOs, flow control, IRQ
//
// Behaviour
// RULE1: full duplex, DMA or software data movement
// RULE2: five to eight data bits
// RULE3: no, even or odd parity
// RULE4: optional address bit, interrupt when addressed
// RULE5: stop of 1, 1.5, 2, 2.5 bits
// RULE6: transmit held while clear-to-send deasserted
// RULE7: RTS follows programmable receive fill thresholds
// RULE8: break command of programmable bit length
// RULE9: programmable inter-frame gap after stop
// RULE10: optional infrared encode and decode
// RULE11: receive line exported for timer measurement
// RULE12: start bit, LSB first, mid-bit sampling
// RULE13: parity, framing, overrun, break flagged to interrupt
`include "asp_consts.svh"
module asp_dev_end #(
    parameter int DEPTH = `ASP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // DMA requests and strobes
    output logic dma_tx_req_out,
    output logic dma_rx_req_out,
    input wire logic dma_tx_wr_in,
    input wire logic [8:0] dma_tx_data_in,
    input wire logic dma_rx_rd_in,
    // Interrupt and timer tap
    output logic irq_out,
    output logic rx_line_tap_out,
    // Link
    asp_link_if.dev link
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [31:0] ctrl, flow, lin, rdata;
        logic [15:0] div;
        logic [`ASP_NST-1:0] stat, mask;
        logic [1:0] cts_s, rx_s;
        logic [AW:0] tw, tr, rw, rr;
        logic rts, rdy, irq, tap, brk, txreq, rxreq;
        logic [DEPTH-1:0][8:0] tq, rq;
    } dev_t;
    dev_t s_ff, nxt_s;
    asp_pkg::asp_cfg_t cfg;
    logic tx_rdy, rv, pe, fe, bk;
    logic [8:0] rd;
    logic [AW:0] tfill, rfill;
    logic acc, wr, rdp;
    function automatic logic [AW:0] fill(input logic [AW:0] w, r);
        fill = w - r;
    endfunction
    ////////////////////////////////////////////////////////////////////
    assign cfg.len_sel = s_ff.ctrl[3:2];
    assign cfg.par = asp_pkg::asp_par_t'(s_ff.ctrl[5:4]);
    assign cfg.stop = asp_pkg::asp_stop_t'(s_ff.ctrl[7:6]);
    assign cfg.addr_bit_en = s_ff.ctrl[8];
    assign cfg.ir_en = s_ff.ctrl[9];
    assign cfg.half_div = s_ff.div;
    assign tfill = fill(s_ff.tw, s_ff.tr);
    assign rfill = fill(s_ff.rw, s_ff.rr);
    assign acc = psel_in && penable_in && !s_ff.rdy;
    assign wr = acc && pwrite_in;
    assign rdp = acc && !pwrite_in;
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rdy = acc;
        nxt_s.cts_s = {s_ff.cts_s[0], link.far_cts};
        nxt_s.rx_s = {s_ff.rx_s[0], link.far_txd};
        nxt_s.tap = s_ff.rx_s[1]; // RULE11
        nxt_s.brk = s_ff.brk && !tx_rdy; // RULE8
        // Transmit queue pops when the engine takes a character
        if (tx_rdy && tfill != '0 && !s_ff.brk)
            nxt_s.tr = s_ff.tr + 1'b1;
        if ((wr && paddr_in == `ASP_REG_TXD || dma_tx_wr_in) &&
            tfill != (AW+1)'(DEPTH)) begin // RULE1
            nxt_s.tq[s_ff.tw[AW-1:0]] = dma_tx_wr_in ? dma_tx_data_in :
                pwdata_in[8:0];
            nxt_s.tw = s_ff.tw + 1'b1;
        end
        // Receive with address filter in multi-drop mode
        if (rv) begin
            if (rfill == (AW+1)'(DEPTH))
                nxt_s.stat[`ASP_ST_OE] = 1'b1; // RULE13
            else if (!cfg.addr_bit_en || !s_ff.ctrl[10] || rd[8]) begin
                nxt_s.rq[s_ff.rw[AW-1:0]] = rd; // RULE4
                nxt_s.rw = s_ff.rw + 1'b1;
                nxt_s.stat[`ASP_ST_RX] = 1'b1;
            end
            if (pe) nxt_s.stat[`ASP_ST_PE] = 1'b1; // RULE13
            if (fe && !bk) nxt_s.stat[`ASP_ST_FE] = 1'b1;
            if (bk) nxt_s.stat[`ASP_ST_BI] = 1'b1;
        end
        if ((rdp && paddr_in == `ASP_REG_RXD || dma_rx_rd_in) &&
            rfill != '0)
            nxt_s.rr = s_ff.rr + 1'b1;
        // Software writes
        if (wr) begin
            unique case (paddr_in)
                `ASP_REG_CTRL: nxt_s.ctrl = pwdata_in;
                `ASP_REG_DIV: nxt_s.div = pwdata_in[15:0];
                `ASP_REG_MASK: nxt_s.mask = pwdata_in[`ASP_NST-1:0];
                `ASP_REG_FLOW: nxt_s.flow = pwdata_in;
                `ASP_REG_LIN: begin
                    nxt_s.lin = pwdata_in;
                    nxt_s.brk = pwdata_in[16]; // RULE8
                end
                default: ;
            endcase
        end
        // Write one to clear; a same-cycle event keeps its bit only if that bit was clear before
        if (wr && paddr_in == `ASP_REG_STAT)
            nxt_s.stat = nxt_s.stat & ~(s_ff.stat & pwdata_in[`ASP_NST-1:0]
                & ~(nxt_s.stat ^ s_ff.stat));
        nxt_s.stat[`ASP_ST_TXE] = (tfill == '0) || nxt_s.stat[`ASP_ST_TXE]
            && !(wr && paddr_in == `ASP_REG_STAT && pwdata_in[`ASP_ST_TXE]);
        // RTS: deassert at high mark, reassert at low mark
        if (s_ff.ctrl[11]) begin
            if (rfill >= (AW+1)'(s_ff.flow[11:8]))
                nxt_s.rts = 1'b0; // RULE7
            else if (rfill <= (AW+1)'(s_ff.flow[3:0]))
                nxt_s.rts = 1'b1;
        end else begin
            nxt_s.rts = 1'b1;
        end
        nxt_s.irq = |(nxt_s.stat & s_ff.mask);
        nxt_s.txreq = s_ff.ctrl[12] && tfill < (AW+1)'(DEPTH - 1);
        nxt_s.rxreq = s_ff.ctrl[13] && rfill != '0;
        nxt_s.rdata = 32'h0;
        if (acc) begin
            unique case (paddr_in)
                `ASP_REG_CTRL: nxt_s.rdata = s_ff.ctrl;
                `ASP_REG_DIV: nxt_s.rdata = {16'h0, s_ff.div};
                `ASP_REG_RXD: nxt_s.rdata = {23'h0, s_ff.rq[s_ff.rr[AW-1:0]]};
                `ASP_REG_STAT: nxt_s.rdata = 32'(s_ff.stat);
                `ASP_REG_MASK: nxt_s.rdata = 32'(s_ff.mask);
                `ASP_REG_FLOW: nxt_s.rdata = s_ff.flow;
                `ASP_REG_LIN: nxt_s.rdata = s_ff.lin;
                default: nxt_s.rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_ff <= '{ctrl: `ASP_CTRL_RST, flow: `ASP_FLOW_RST,
                div: `ASP_DIV_RST, cts_s: 2'h0, rx_s: 2'h3, rts: 1'b1,
                tap: 1'b1, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end
    ////////////////////////////////////////////////////////////////////
    asp_serial_engine u_eng (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .cfg_in(cfg),
        .gap_bits_in(s_ff.lin[7:0]), // RULE9
        .cts_gate_in(!s_ff.ctrl[14] || s_ff.cts_s[1]), // RULE6
        .tx_valid_in(tfill != '0),
        .tx_data_in(s_ff.tq[s_ff.tr[AW-1:0]]),
        .tx_break_in(s_ff.brk),
        .brk_bits_in(s_ff.lin[15:8]),
        .tx_ready_out(tx_rdy),
        .rx_valid_out(rv),
        .rx_data_out(rd),
        .rx_perr_out(pe),
        .rx_ferr_out(fe),
        .rx_brk_out(bk),
        .rxd_in(s_ff.rx_s[1]),
        .txd_out(link.dev_txd)
    );
    assign link.dev_rts = s_ff.rts;
    assign prdata_out = s_ff.rdata;
    assign pready_out = s_ff.rdy;
    assign pslverr_out = 1'b0;
    assign irq_out = s_ff.irq;
    assign rx_line_tap_out = s_ff.tap;
    assign dma_tx_req_out = s_ff.txreq;
    assign dma_rx_req_out = s_ff.rxreq;
endmodule

// [asp_far_end.sv]
// Remote party: plain user-side streaming over the serial lines
module asp_far_end (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Frame settings, same as the port, and the clear-to-send grant
    input wire asp_pkg::asp_cfg_t cfg_in,
    input wire logic grant_in,
    // Transmit
    input wire logic tx_valid_in,
    input wire logic [8:0] tx_data_in,
    output logic tx_ready_out,
    // Receive
    output logic rx_valid_out,
    output logic [8:0] rx_data_out,
    output logic rx_err_out,
    output logic dev_rts_out,
    // Link
    asp_link_if.far link
);
    logic rv, pe, fe, bk, txd, rdy;
    logic [8:0] rd;
    logic [1:0] rts_sync_ff;
    logic cts_ff, vld_ff, err_ff;
    logic [8:0] dat_ff;
    // RTS from the port is a pin: two flops before use
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rts_sync_ff <= 2'h0;
            cts_ff <= 1'b0;
            vld_ff <= 1'b0;
            err_ff <= 1'b0;
            dat_ff <= 9'h0;
        end else begin
            rts_sync_ff <= {rts_sync_ff[0], link.dev_rts};
            cts_ff <= grant_in; // RULE6
            vld_ff <= rv;
            err_ff <= rv && (pe || fe || bk);
            if (rv)
                dat_ff <= rd;
        end
    end
    asp_serial_engine u_eng (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .cfg_in(cfg_in),
        .gap_bits_in(8'h0),
        .cts_gate_in(rts_sync_ff[1]), // RULE6
        .tx_valid_in(tx_valid_in),
        .tx_data_in(tx_data_in),
        .tx_break_in(1'b0),
        .brk_bits_in(8'h0),
        .tx_ready_out(rdy),
        .rx_valid_out(rv),
        .rx_data_out(rd),
        .rx_perr_out(pe),
        .rx_ferr_out(fe),
        .rx_brk_out(bk),
        .rxd_in(link.dev_txd),
        .txd_out(txd)
    );
    assign link.far_txd = txd;
    assign link.far_cts = cts_ff;
    assign tx_ready_out = rdy;
    assign rx_valid_out = vld_ff;
    assign rx_data_out = dat_ff;
    assign rx_err_out = err_ff;
    assign dev_rts_out = rts_sync_ff[1];
endmodule

// [asp_link_if.sv]
// Serial lines between the port and the remote party
interface asp_link_if;
    logic dev_txd;
    logic dev_rts;
    logic far_txd;
    logic far_cts;
    modport dev (output dev_txd, output dev_rts, input far_txd,
        input far_cts);
    modport far (input dev_txd, input dev_rts, output far_txd,
        output far_cts);
endinterface

// [asp_link_sva.sv]
// Line-level checks on the link joining the port and the remote party
module asp_link_sva #(
    parameter int BIT_CLKS = 4
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Serial lines
    input wire logic dev_txd,
    input wire logic dev_rts,
    input wire logic far_txd,
    input wire logic far_cts
);
    logic [7:0] dev_lo_ff;
    logic [7:0] far_lo_ff;
    ////////////////////////////////////////////////////////////////////////
    // Low-run lengths saturate so a stuck line cannot wrap to a legal size
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dev_lo_ff <= 8'h00;
            far_lo_ff <= 8'h00;
        end else begin
            dev_lo_ff <= dev_txd ? 8'h00 : dev_lo_ff + {7'h0, ~&dev_lo_ff};
            far_lo_ff <= far_txd ? 8'h00 : far_lo_ff + {7'h0, ~&far_lo_ff};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    a_dev_bit_hold: assert property ($changed(dev_txd) |=> $stable(dev_txd) [*3])
        else $error("port line level shorter than a bit");
    a_far_bit_hold: assert property ($changed(far_txd) |=> $stable(far_txd) [*3])
        else $error("far line level shorter than a bit");
    a_dev_low_whole: assert property (
        $rose(dev_txd) |-> (dev_lo_ff % 8'(BIT_CLKS)) == 8'h00)
        else $error("port low run not whole bits");
    a_far_low_whole: assert property (
        $rose(far_txd) |-> (far_lo_ff % 8'(BIT_CLKS)) == 8'h00)
        else $error("far low run not whole bits");
    a_dev_low_max: assert property (dev_lo_ff <= 8'd62)
        else $error("port low run beyond longest break");
    a_far_low_max: assert property (far_lo_ff <= 8'd40)
        else $error("far low run beyond longest frame");
    a_cts_holds_tx: assert property (
        (dev_txd && !far_cts) [*8] |=> dev_txd)
        else $error("port started a frame without clear to send");
    a_rts_holds_far: assert property (
        (far_txd && !dev_rts) [*8] |=> far_txd)
        else $error("far end started a frame while held off");
endmodule

// [asp_pkg.sv]
// Types shared by both ends of the serial link
package asp_pkg;
    typedef enum logic [1:0] {
        ASP_PAR_NONE = 2'h0,
        ASP_PAR_EVEN = 2'h1,
        ASP_PAR_ODD = 2'h2
    } asp_par_t;
    typedef enum logic [1:0] {
        ASP_STOP_1 = 2'h0,
        ASP_STOP_15 = 2'h1,
        ASP_STOP_2 = 2'h2,
        ASP_STOP_25 = 2'h3
    } asp_stop_t;
    typedef enum logic [4:0] {
        ASP_TX_IDLE = 5'h01,
        ASP_TX_START = 5'h02,
        ASP_TX_BITS = 5'h04,
        ASP_TX_STOP = 5'h08,
        ASP_TX_GAP = 5'h10
    } asp_txs_t;
    typedef enum logic [3:0] {
        ASP_RX_IDLE = 4'h1,
        ASP_RX_START = 4'h2,
        ASP_RX_BITS = 4'h4,
        ASP_RX_STOP = 4'h8
    } asp_rxs_t;
    // Frame shape, agreed identically by both ends
    typedef struct packed {
        logic [1:0] len_sel;
        asp_par_t par;
        asp_stop_t stop;
        logic addr_bit_en;
        logic ir_en;
        logic [15:0] half_div;
    } asp_cfg_t;
endpackage

// [asp_serial_engine.sv]
// Serial transmit and receive engine shared by both ends
//
// The address map and the APB interface to the registers were decided locally.
`include "asp_consts.svh"
module asp_serial_engine (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Configuration
    input wire asp_pkg::asp_cfg_t cfg_in,
    input wire logic [7:0] gap_bits_in,
    input wire logic cts_gate_in,
    // Transmit request
    input wire logic tx_valid_in,
    input wire logic [8:0] tx_data_in,
    input wire logic tx_break_in,
    input wire logic [7:0] brk_bits_in,
    output logic tx_ready_out,
    // Receive result
    output logic rx_valid_out,
    output logic [8:0] rx_data_out,
    output logic rx_perr_out,
    output logic rx_ferr_out,
    output logic rx_brk_out,
    // Line
    input wire logic rxd_in,
    output logic txd_out
);
    typedef struct packed {
        logic rx_m1, rx_m2;
        asp_pkg::asp_txs_t ts;
        logic [16:0] tcnt;
        logic [4:0] thalf;
        logic [3:0] tbit;
        logic [10:0] tsh;
        logic tbrk;
        logic txd;
        asp_pkg::asp_rxs_t rs;
        logic [16:0] rcnt;
        logic [3:0] rbit;
        logic [10:0] rsh;
        logic rv;
        logic [8:0] rd;
        logic pe, fe, bi;
    } eng_t;
    eng_t st_ff, nxt_st;
    // Data bits per frame: five to eight, plus one when the address bit is enabled
    function automatic logic [3:0] nbits(input asp_pkg::asp_cfg_t c);
        nbits = 4'h5 + {2'h0, c.len_sel} + {3'h0, c.addr_bit_en}; // RULE2 RULE4
    endfunction
    function automatic logic par_of(input logic [8:0] d,
        input asp_pkg::asp_cfg_t c);
        logic [8:0] m;
        m = 9'h1ff >> (4'h9 - nbits(c));
        par_of = ^(d & m) ^ (c.par == asp_pkg::ASP_PAR_ODD); // RULE3
    endfunction
    // Frame length after the start bit, in half bits
    function automatic logic [4:0] total_halves(input asp_pkg::asp_cfg_t c);
        total_halves = 5'((nbits(c) + 4'((c.par != asp_pkg::ASP_PAR_NONE)
            ? 1 : 0)) << 1) + 5'h2 + {3'h0, c.stop}; // RULE5
    endfunction
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rx_m1 = rxd_in;
        nxt_st.rx_m2 = st_ff.rx_m1;
        nxt_st.rv = 1'b0;
        // Transmitter: one counter step per half bit
        unique case (st_ff.ts)
            asp_pkg::ASP_TX_IDLE: begin
                nxt_st.txd = 1'b1;
                if (tx_break_in && cts_gate_in) begin
                    nxt_st.tbrk = 1'b1; // RULE8
                    nxt_st.thalf = 5'(brk_bits_in << 1);
                    nxt_st.tcnt = 17'h0;
                    nxt_st.ts = asp_pkg::ASP_TX_BITS;
                    nxt_st.tsh = 11'h0;
                end else if (tx_valid_in && cts_gate_in) begin // RULE6
                    nxt_st.tbrk = 1'b0;
                    nxt_st.tsh = (11'h7ff << nbits(cfg_in)) | {2'h0,
                        tx_data_in};
                    if (cfg_in.par != asp_pkg::ASP_PAR_NONE)
                        nxt_st.tsh[nbits(cfg_in)] = par_of(tx_data_in, cfg_in);
                    nxt_st.thalf = total_halves(cfg_in);
                    nxt_st.tcnt = 17'h0;
                    nxt_st.tbit = 4'h0;
                    nxt_st.ts = asp_pkg::ASP_TX_START;
                end
            end
            asp_pkg::ASP_TX_START, asp_pkg::ASP_TX_BITS,
            asp_pkg::ASP_TX_STOP, asp_pkg::ASP_TX_GAP: begin
                // Start bit low, then LSB first from the shifter
                if (st_ff.ts == asp_pkg::ASP_TX_START)
                    nxt_st.txd = 1'b0; // RULE12
                else if (st_ff.ts == asp_pkg::ASP_TX_GAP)
                    nxt_st.txd = 1'b1; // RULE9
                else
                    nxt_st.txd = st_ff.tbrk ? 1'b0 : st_ff.tsh[0]; // RULE8 RULE12
                if (cfg_in.ir_en)
                    nxt_st.txd = ~(!nxt_st.txd && st_ff.tcnt <
                        17'((cfg_in.half_div * 3) >> 3)); // RULE10
                if (st_ff.tcnt >= {1'b0, cfg_in.half_div}) begin
                    nxt_st.tcnt = 17'h0;
                    nxt_st.tbit = st_ff.tbit + 4'h1;
                    if (st_ff.ts == asp_pkg::ASP_TX_START) begin
                        if (st_ff.tbit[0]) begin
                            nxt_st.ts = asp_pkg::ASP_TX_BITS;
                            nxt_st.tbit = 4'h0;
                        end
                    end else if (st_ff.ts == asp_pkg::ASP_TX_GAP) begin
                        nxt_st.thalf = st_ff.thalf - 5'h1;
                        if (st_ff.thalf <= 5'h1)
                            nxt_st.ts = asp_pkg::ASP_TX_IDLE;
                    end else begin
                        nxt_st.thalf = st_ff.thalf - 5'h1;
                        if (st_ff.tbit[0])
                            nxt_st.tsh = {1'b1, st_ff.tsh[10:1]};
                        if (st_ff.thalf <= 5'h1) begin
                            nxt_st.ts = (gap_bits_in != 8'h0) ?
                                asp_pkg::ASP_TX_GAP : asp_pkg::ASP_TX_IDLE;
                            nxt_st.thalf = 5'(gap_bits_in << 1);
                        end
                    end
                end else begin
                    nxt_st.tcnt = st_ff.tcnt + 17'h1;
                end
            end
            default: nxt_st.ts = asp_pkg::ASP_TX_IDLE;
        endcase
        // Receiver: sample mid bit
        unique case (st_ff.rs)
            asp_pkg::ASP_RX_IDLE: begin
                if (st_ff.rx_m2 == cfg_in.ir_en) begin
                    nxt_st.rs = asp_pkg::ASP_RX_START;
                    nxt_st.rcnt = 17'h0;
                    nxt_st.rsh = 11'h0;
                    nxt_st.rbit = 4'h0;
                end
            end
            asp_pkg::ASP_RX_START, asp_pkg::ASP_RX_BITS,
            asp_pkg::ASP_RX_STOP: begin
                nxt_st.rcnt = st_ff.rcnt + 17'h1;
                if (st_ff.rcnt == {1'b0, cfg_in.half_div} &&
                    st_ff.rs == asp_pkg::ASP_RX_START) begin
                    nxt_st.rcnt = 17'h0;
                    nxt_st.rs = asp_pkg::ASP_RX_BITS; // RULE12
                end else if (st_ff.rcnt == {cfg_in.half_div, 1'b1}) begin
                    nxt_st.rcnt = 17'h0;
                    nxt_st.rsh = {st_ff.rx_m2 ^ cfg_in.ir_en, st_ff.rsh[10:1]};
                    nxt_st.rbit = st_ff.rbit + 4'h1;
                    if (st_ff.rbit == nbits(cfg_in) +
                        4'((cfg_in.par != asp_pkg::ASP_PAR_NONE) ? 1 : 0)) begin
                        nxt_st.rs = asp_pkg::ASP_RX_IDLE;
                        nxt_st.rv = 1'b1;
                        nxt_st.rd = 9'(nxt_st.rsh >> (4'ha - st_ff.rbit));
                        nxt_st.rd = nxt_st.rd & (9'h1ff >> (4'h9 - nbits(cfg_in)));
                        nxt_st.fe = !(st_ff.rx_m2 ^ cfg_in.ir_en); // RULE13
                        nxt_st.pe = (cfg_in.par != asp_pkg::ASP_PAR_NONE) &&
                            (nxt_st.rsh[9] != par_of(nxt_st.rd, cfg_in));
                        nxt_st.bi = (nxt_st.rsh == 11'h0); // RULE13
                    end
                end
            end
            default: nxt_st.rs = asp_pkg::ASP_RX_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= '{rx_m1: 1'b1, rx_m2: 1'b1, ts: asp_pkg::ASP_TX_IDLE,
                rs: asp_pkg::ASP_RX_IDLE, txd: 1'b1, tsh: 11'h7ff,
                default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign txd_out = st_ff.txd;
    assign tx_ready_out = (st_ff.ts == asp_pkg::ASP_TX_IDLE) && cts_gate_in;
    assign rx_valid_out = st_ff.rv;
    assign rx_data_out = st_ff.rd;
    assign rx_perr_out = st_ff.pe;
    assign rx_ferr_out = st_ff.fe;
    assign rx_brk_out = st_ff.bi;
endmodule

// [tb_top.sv]
// Bench: APB side of the port against the remote party's user side
`include "asp_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0, rstn_in = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, dtwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, irq, dtreq, ftr, frv, grant = 1'b1, ftv = 1'b0;
    logic [8:0] dtdata = 9'h000, ftd = 9'h000, frd, d, m;
    asp_pkg::asp_cfg_t fcfg = '0;
    logic [8:0] fq[$];
    int err_total = 0, compares = 0, cyc = 0, n;
    asp_link_if link ();
    asp_dev_end u_asp_dev_end (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(), .dma_tx_req_out(dtreq),
        .dma_rx_req_out(), .dma_tx_wr_in(dtwr), .dma_tx_data_in(dtdata),
        .dma_rx_rd_in(1'b0), .irq_out(irq), .rx_line_tap_out(),
        .link(link.dev));
    asp_far_end u_asp_far_end (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .cfg_in(fcfg), .grant_in(grant), .tx_valid_in(ftv),
        .tx_data_in(ftd), .tx_ready_out(ftr), .rx_valid_out(frv),
        .rx_data_out(frd), .rx_err_out(), .dev_rts_out(),
        .link(link.far));
    asp_link_sva #(.BIT_CLKS(4)) u_asp_link_sva (.clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in), .dev_txd(link.dev_txd), .dev_rts(link.dev_rts),
        .far_txd(link.far_txd), .far_cts(link.far_cts));
    ////////////////////////////////////////////////////////////////////////
    always #2 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc++;
        if (frv === 1'b1) fq.push_back(frd);
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compares %0d, errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] q);
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys_in);
        pen <= 1'b1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] q;
        apb(1'b1, a, wd, q);
    endtask
    task automatic rd(input string nm, input logic [11:0] a,
        input logic [31:0] mk, e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        cmp(nm, e, q & mk);
    endtask
    task automatic wait_far(input logic [8:0] e);
        for (int k = 0; k < 2000 && fq.size() == 0; k++) @(posedge clk_sys_in);
        if (fq.size() == 0) fq.push_back(~e);
        cmp("far rx", {23'h0, e}, {23'h0, fq.pop_front()});
    endtask
    task automatic wait_irq();
        for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(negedge clk_sys_in);
        cmp("irq", 32'h1, {31'h0, irq});
    endtask
    task automatic fsend(input logic [8:0] fd);
        @(posedge clk_sys_in);
        ftv <= 1'b1;
        ftd <= fd;
        do @(posedge clk_sys_in); while (ftr !== 1'b1);
        ftv <= 1'b0;
    endtask
    // Length in cycles of the next run of the port line at one level
    task automatic run(input logic lv, output int len);
        len = 0;
        for (int k = 0; k < 2000 && link.dev_txd !== lv; k++) @(negedge clk_sys_in);
        while (link.dev_txd === lv && len < 2000) begin
            @(negedge clk_sys_in);
            len++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        fcfg.half_div = 16'h0001;
        repeat (12) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        rd("ctrl", `ASP_REG_CTRL, 32'hffff_ffff, `ASP_CTRL_RST);
        rd("flow", `ASP_REG_FLOW, 32'hffff_ffff, `ASP_FLOW_RST);
        rd("div", `ASP_REG_DIV, 32'hffff_ffff, {16'h0, `ASP_DIV_RST});
        rd("unmapped", 12'h020, 32'hffff_ffff, 32'h0);
        wr(`ASP_REG_DIV, 32'h1);
        wr(`ASP_REG_MASK, 32'h1);
        for (int p = 0; p < 3; p++) begin
            for (int l = 0; l < 4; l++) begin
                fcfg.len_sel <= l[1:0];
                fcfg.par <= asp_pkg::asp_par_t'(p[1:0]);
                fcfg.stop <= asp_pkg::asp_stop_t'(l[1:0]);
                m = 9'h0ff >> (3 - l);
                d = 9'h0a5 ^ 9'(p * 4 + l);
                wr(`ASP_REG_CTRL, 32'h4000 | 32'(p * 16 + l * 68));
                wr(`ASP_REG_TXD, {23'h0, d});
                fsend(~d);
                wait_far(d & m);
                wait_irq();
                rd("rxd", `ASP_REG_RXD, 32'h1ff, {23'h0, ~d & m});
                wr(`ASP_REG_STAT, 32'h3f);
            end
        end
        wr(`ASP_REG_MASK, 32'h4);
        fcfg.par <= asp_pkg::ASP_PAR_EVEN;
        fsend(9'h001);
        wait_irq();
        rd("stat", `ASP_REG_STAT, 32'h3d, 32'h05);
        wr(`ASP_REG_STAT, 32'h4);
        rd("stat", `ASP_REG_STAT, 32'h3d, 32'h01);
        cmp("irq", 32'h0, {31'h0, irq});
        rd("rxd", `ASP_REG_RXD, 32'h1ff, 32'h001);
        fcfg.par <= asp_pkg::ASP_PAR_NONE;
        fcfg.stop <= asp_pkg::ASP_STOP_1;
        wr(`ASP_REG_CTRL, 32'h400c);
        grant <= 1'b0;
        wr(`ASP_REG_TXD, 32'h55);
        repeat (200) @(posedge clk_sys_in);
        cmp("far idle", 32'h0, 32'(fq.size()));
        grant <= 1'b1;
        wait_far(9'h055);
        wr(`ASP_REG_LIN, 32'h3);
        wr(`ASP_REG_TXD, 32'h0);
        wr(`ASP_REG_TXD, 32'h0);
        run(1'b0, n);
        run(1'b1, n);
        // Stop, gap, then one idle clock before the start bit
        cmp("gap", 32'd17, 32'(n));
        run(1'b0, n);
        cmp("low run", 32'd36, 32'(n));
        wr(`ASP_REG_LIN, 32'h0001_0c00);
        run(1'b1, n);
        run(1'b0, n);
        cmp("break", 32'd48, 32'(n));
        repeat (100) @(posedge clk_sys_in);
        fq.delete();
        wr(`ASP_REG_FLOW, 32'h100);
        wr(`ASP_REG_CTRL, 32'h480c);
        fsend(9'h011);
        for (n = 0; n < 500 && link.dev_rts !== 1'b0; n++) @(negedge clk_sys_in);
        cmp("rts", 32'h0, {31'h0, link.dev_rts});
        repeat (40) @(posedge clk_sys_in);
        rd("rxd", `ASP_REG_RXD, 32'h1ff, 32'h011);
        rd("flow", `ASP_REG_FLOW, 32'hfff, 32'h100);
        cmp("rts", 32'h1, {31'h0, link.dev_rts});
        wr(`ASP_REG_CTRL, 32'h500c);
        @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        cmp("dma req", 32'h1, {31'h0, dtreq});
        @(posedge clk_sys_in);
        dtwr <= 1'b1;
        dtdata <= 9'h05a;
        @(posedge clk_sys_in);
        dtwr <= 1'b0;
        wait_far(9'h05a);
        conclude();
    end
endmodule
